// file: hdl/isms_slave.sv
// Two-wire serial slave with its byte memory
`timescale 1ns/10ps
`default_nettype none
module isms_slave
    import isms_pkg::*;
#(
    parameter int FIFO_DEPTH = ISMS_FIFO_DEPTH,
    parameter int FILT_CYC   = ISMS_GLITCH_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    input  wire logic [ISMS_SEL_W-1:0] device_select_pins,
    output var  logic                  sda_o,
    output var  logic                  sda_oe,
    output var  logic                  hs_mode
);
    localparam int AW = ISMS_ADDR_W;
    localparam int DW = ISMS_DATA_W;
    localparam int HW = AW - DW;
    localparam int FW = AW + DW;

    // ==========================================================
    // Line conditioning
    // Serial clock is only ever sampled, never driven
    logic scl_f;
    logic sda_f;
    logic scl_d_r;
    logic sda_d_r;
    logic [ISMS_SEL_W-1:0] sel_s1_r;
    logic [ISMS_SEL_W-1:0] sel_s2_r;

    isms_filter #(
        .STAGES  (FILT_CYC),
        .RST_LVL (ISMS_LINE_IDLE)
    ) u_scl_filt (
        .mclk    (mclk),
        .rst     (rst),
        .clk_en  (clk_en),
        .raw_i   (scl_i),
        .clean_o (scl_f)
    );

    isms_filter #(
        .STAGES  (FILT_CYC),
        .RST_LVL (ISMS_LINE_IDLE)
    ) u_sda_filt (
        .mclk    (mclk),
        .rst     (rst),
        .clk_en  (clk_en),
        .raw_i   (sda_i),
        .clean_o (sda_f)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_d_r  <= ISMS_LINE_IDLE;
            sda_d_r  <= ISMS_LINE_IDLE;
            sel_s1_r <= '0;
            sel_s2_r <= '0;
        end else if (clk_en) begin
            scl_d_r  <= scl_f;
            sda_d_r  <= sda_f;
            sel_s1_r <= device_select_pins;
            sel_s2_r <= sel_s1_r;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_f && !scl_d_r;
    assign scl_fall  = !scl_f && scl_d_r;
    // Data edges count only while clock stays high across both samples
    assign start_det = scl_f && scl_d_r && sda_d_r && !sda_f;
    assign stop_det  = scl_f && scl_d_r && !sda_d_r && sda_f;

    // ==========================================================
    // Helpers
    function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
        // Natural overflow gives the wrap from the top location to zero
        addr_inc = a + AW'(ISMS_ADDR_STEP);
    endfunction

    function automatic logic addr_match(input logic [DW-1:0] b,
                                        input logic [ISMS_SEL_W-1:0] s);
        addr_match = (b[ISMS_TYPE_HI:ISMS_TYPE_LO] == ISMS_DEV_TYPE) &&
                     (b[ISMS_SEL_HI:ISMS_SEL_LO] == s);
    endfunction

    // ==========================================================
    // Protocol engine
    isms_state_t   state_r;
    isms_state_t   state_nxt;
    isms_role_t    role_r;
    isms_role_t    role_nxt;
    logic [3:0]    cnt_r;
    logic [3:0]    cnt_nxt;
    logic [DW-1:0] sh_r;
    logic [DW-1:0] sh_nxt;
    logic [HW-1:0] hi_r;
    logic [HW-1:0] hi_nxt;
    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic          acked_r;
    logic          acked_nxt;
    logic          oe_r;
    logic          oe_nxt;
    logic          hs_r;
    logic          hs_nxt;
    logic          push_v;
    logic          push_rdy;
    logic [DW-1:0] rd_data_r;

    always_comb begin
        state_nxt = state_r;
        role_nxt  = role_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        hi_nxt    = hi_r;
        addr_nxt  = addr_r;
        acked_nxt = acked_r;
        oe_nxt    = oe_r;
        hs_nxt    = hs_r;
        push_v    = 1'b0;
        if (stop_det) begin
            state_nxt = ST_IDLE;
            oe_nxt    = 1'b0;
            hs_nxt    = 1'b0;
        end else if (start_det) begin
            state_nxt = ST_RX;
            role_nxt  = ROLE_SADDR;
            cnt_nxt   = '0;
            oe_nxt    = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_IGNORE: begin
                    oe_nxt = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt  = {sh_r[DW-2:0], sda_f};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == ISMS_BYTE_BITS) begin
                        cnt_nxt   = '0;
                        state_nxt = ST_ACK;
                        oe_nxt    = 1'b1;
                        unique case (role_r)
                            ROLE_SADDR: begin
                                if (sh_r[ISMS_MCODE_HI:ISMS_MCODE_LO] ==
                                    ISMS_MCODE) begin
                                    // Master codes are never acknowledged
                                    hs_nxt    = 1'b1;
                                    state_nxt = ST_IGNORE;
                                    oe_nxt    = 1'b0;
                                end else if (addr_match(sh_r, sel_s2_r)) begin
                                    role_nxt = (sh_r[ISMS_RW_BIT] ==
                                                ISMS_RW_READ) ?
                                               ROLE_READ : ROLE_AHI;
                                end else begin
                                    state_nxt = ST_IGNORE;
                                    oe_nxt    = 1'b0;
                                end
                            end
                            ROLE_AHI: begin
                                hi_nxt   = sh_r[HW-1:0];
                                role_nxt = ROLE_ALO;
                            end
                            ROLE_ALO: begin
                                addr_nxt = {hi_r, sh_r};
                                role_nxt = ROLE_WDATA;
                            end
                            ROLE_WDATA: begin
                                // Full buffer: the byte is refused by a nack
                                push_v = 1'b1;
                                if (push_rdy) begin
                                    addr_nxt = addr_inc(addr_r);
                                end else begin
                                    state_nxt = ST_IGNORE;
                                    oe_nxt    = 1'b0;
                                end
                            end
                            ROLE_READ: begin
                                state_nxt = ST_IGNORE;
                                oe_nxt    = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (role_r == ROLE_READ) begin
                            state_nxt = ST_TX;
                            sh_nxt    = rd_data_r;
                            oe_nxt    = !rd_data_r[DW-1];
                            cnt_nxt   = '0;
                        end else begin
                            state_nxt = ST_RX;
                            oe_nxt    = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == ISMS_BYTE_BITS) begin
                            state_nxt = ST_RACK;
                            oe_nxt    = 1'b0;
                            addr_nxt  = addr_inc(addr_r);
                        end else begin
                            sh_nxt = {sh_r[DW-2:0], 1'b0};
                            oe_nxt = !sh_r[DW-2];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        acked_nxt = !sda_f;
                    end else if (scl_fall) begin
                        if (acked_r) begin
                            state_nxt = ST_TX;
                            sh_nxt    = rd_data_r;
                            oe_nxt    = !rd_data_r[DW-1];
                            cnt_nxt   = '0;
                        end else begin
                            state_nxt = ST_IGNORE;
                            oe_nxt    = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            role_r  <= ROLE_SADDR;
            cnt_r   <= '0;
            sh_r    <= '0;
            hi_r    <= '0;
            addr_r  <= AW'(ISMS_ADDR_RST);
            acked_r <= 1'b0;
            oe_r    <= 1'b0;
            hs_r    <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            role_r  <= role_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            hi_r    <= hi_nxt;
            addr_r  <= addr_nxt;
            acked_r <= acked_nxt;
            oe_r    <= oe_nxt;
            hs_r    <= hs_nxt;
        end
    end

    // ==========================================================
    // Write buffer and memory
    logic          drain_v;
    logic          drain_rdy;
    logic [FW-1:0] drain_w;
    logic [DW-1:0] mem [2**AW];

    isms_fifo #(
        .WIDTH     (FW),
        .DEPTH     (FIFO_DEPTH)
    ) u_wbuf (
        .mclk      (mclk),
        .rst       (rst),
        .clk_en    (clk_en),
        .in_valid  (push_v),
        .in_ready  (push_rdy),
        .in_data   ({addr_r, sh_r}),
        .out_valid (drain_v),
        .out_ready (drain_rdy),
        .out_data  (drain_w)
    );

    // Single memory port: the master-ack phase keeps it for the prefetch
    assign drain_rdy = (state_r != ST_RACK);

    // Drains within a few cycles, far inside one serial bit time
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            if (drain_v && drain_rdy) begin
                mem[drain_w[FW-1:DW]] <= drain_w[DW-1:0];
            end else begin
                rd_data_r <= mem[addr_r];
            end
        end
    end

    // ==========================================================
    // Outputs
    logic sda_o_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_o_r <= ISMS_SDA_LOW;
        end else if (clk_en) begin
            sda_o_r <= ISMS_SDA_LOW;
        end
    end

    assign sda_o   = sda_o_r;
    assign sda_oe  = oe_r;
    assign hs_mode = hs_r;
endmodule
`default_nettype wire

// file: hdl/isms_pkg.sv
// Constants and types shared by the serial memory slave
package isms_pkg;

    // ==========================================================
    // Widths and field positions
    localparam int          ISMS_ADDR_W     = 15;
    localparam int          ISMS_DATA_W     = 8;
    localparam logic [3:0]  ISMS_BYTE_BITS  = 4'h8;
    localparam int          ISMS_TYPE_HI    = 7;
    localparam int          ISMS_TYPE_LO    = 4;
    localparam int          ISMS_SEL_HI     = 3;
    localparam int          ISMS_SEL_LO     = 1;
    localparam int          ISMS_RW_BIT     = 0;
    localparam int          ISMS_MCODE_HI   = 7;
    localparam int          ISMS_MCODE_LO   = 3;
    localparam int          ISMS_SEL_W      = 3;

    // ==========================================================
    // Codes and reset values
    localparam logic [3:0]  ISMS_DEV_TYPE   = 4'ha;
    localparam logic [4:0]  ISMS_MCODE      = 5'h01;
    localparam logic [14:0] ISMS_ADDR_RST   = 15'h0000;
    localparam logic [14:0] ISMS_ADDR_STEP  = 15'h0001;
    localparam logic        ISMS_LINE_IDLE  = 1'b1;
    localparam logic        ISMS_SDA_LOW    = 1'b0;
    localparam logic        ISMS_RW_READ    = 1'b1;

    // ==========================================================
    // Timing
    localparam int          ISMS_CLK_PS     = 4000;
    localparam int          ISMS_GLITCH_NS  = 8;
    localparam int          ISMS_GLITCH_CYC =
        (ISMS_GLITCH_NS * 1000 + ISMS_CLK_PS - 1) / ISMS_CLK_PS;
    localparam int          ISMS_FIFO_DEPTH = 4;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_RACK,
        ST_IGNORE
    } isms_state_t;

    typedef enum logic [2:0] {
        ROLE_SADDR,
        ROLE_AHI,
        ROLE_ALO,
        ROLE_WDATA,
        ROLE_READ
    } isms_role_t;

endpackage

// file: hdl/isms_filter.sv
// Two-flop synchroniser with a stability filter for one pin
`timescale 1ns/10ps
`default_nettype none
module isms_filter #(
    parameter int   STAGES  = 2,
    parameter logic RST_LVL = 1'b1
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic raw_i,
    output var  logic clean_o
);
    localparam int CW = $clog2(STAGES + 1);

    logic          s1_r;
    logic          s2_r;
    logic          clean_r;
    logic          clean_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // ==========================================================
    // Level must hold STAGES cycles before it is believed
    always_comb begin
        clean_nxt = clean_r;
        cnt_nxt   = cnt_r;
        if (s2_r == clean_r) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(STAGES - 1)) begin
            clean_nxt = s2_r;
            cnt_nxt   = '0;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_r    <= RST_LVL;
            s2_r    <= RST_LVL;
            clean_r <= RST_LVL;
            cnt_r   <= '0;
        end else if (clk_en) begin
            s1_r    <= raw_i;
            s2_r    <= s1_r;
            clean_r <= clean_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign clean_o = clean_r;
endmodule
`default_nettype wire

// file: hdl/isms_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module isms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    // DEPTH must be a power of two; pointers carry a wrap bit
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_r;
    logic [PW:0]      wr_nxt;
    logic [PW:0]      rd_r;
    logic [PW:0]      rd_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = !((wr_r[PW] != rd_r[PW]) &&
                         (wr_r[PW-1:0] == rd_r[PW-1:0]));
    assign out_valid = (wr_r != rd_r);
    assign out_data  = mem[rd_r[PW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ==========================================================
    // Pointers
    always_comb begin
        wr_nxt = push ? wr_r + (PW+1)'(1) : wr_r;
        rd_nxt = pop  ? rd_r + (PW+1)'(1) : rd_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else if (clk_en) begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // ==========================================================
    // Storage
    always_ff @(posedge mclk) begin
        if (clk_en && push) begin
            mem[wr_r[PW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// file: testbench/isms_master_model.sv
// Bus master model that clocks the link and shares the data wire
`timescale 1ns/10ps
`default_nettype none
module isms_master_model (
    input  wire logic mclk,
    input  wire logic sda_wire,
    output var  logic scl,
    output var  logic sda_m
);
    // ==========================================================
    // Link timing: 48 ns bit period at a 4 ns system clock
    localparam int HALF = 6;

    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // ==========================================================
    // Bit, condition and byte tasks
    // Data moves only while the clock is low
    task automatic bit_xfer(input logic b, output logic r);
        sda_m <= b;
        wait_cyc(HALF);
        scl <= 1'b1;
        wait_cyc(HALF);
        r = sda_wire;
        scl <= 1'b0;
    endtask

    task automatic start;
        sda_m <= 1'b1;
        wait_cyc(HALF);
        scl <= 1'b1;
        wait_cyc(HALF);
        sda_m <= 1'b0;
        wait_cyc(HALF);
        scl <= 1'b0;
    endtask

    // Only called while the master owns the data wire
    task automatic stop;
        sda_m <= 1'b0;
        wait_cyc(HALF);
        scl <= 1'b1;
        wait_cyc(HALF);
        sda_m <= 1'b1;
        wait_cyc(2 * HALF);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = !r;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// file: testbench/isms_slave_assertions.sv
// Concurrent checks on the serial memory slave ports
`timescale 1ns/10ps
`default_nettype none
module isms_slave_assertions
    import isms_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic hs_mode
);
    // ==========================================================
    // Cycles since the clock pin last fell, saturating
    logic [3:0] fall_cnt_r;
    logic [3:0] fall_cnt_nxt;
    logic       scl_d_r;

    always_comb begin
        fall_cnt_nxt = fall_cnt_r;
        if (scl_d_r && !scl_i) begin
            fall_cnt_nxt = 4'h0;
        end else if (fall_cnt_r != 4'hf) begin
            fall_cnt_nxt = fall_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fall_cnt_r <= 4'hf;
            scl_d_r    <= 1'b1;
        end else begin
            fall_cnt_r <= fall_cnt_nxt;
            scl_d_r    <= scl_i;
        end
    end

    // ==========================================================
    // Properties; conditions need the clock high three cycles so
    // a late release near a rising edge is not taken as one
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_oe_after_fall: assert property (
        $changed(sda_oe) |-> fall_cnt_r >= 4'h2 && fall_cnt_r <= 4'h8)
        else $error("data drive changed away from a clock fall");
    a_stop_releases: assert property (
        scl_i && $past(scl_i, 3) && sda_i && !$past(sda_i)
        |-> !sda_oe [*8])
        else $error("data driven after a stop");
    a_start_releases: assert property (
        scl_i && $past(scl_i, 3) && !sda_i && $past(sda_i)
        |-> !sda_oe [*8])
        else $error("data driven after a start");
    a_hs_clear: assert property (
        scl_i && $past(scl_i, 3) && sda_i && !$past(sda_i)
        |-> ##[1:8] !hs_mode)
        else $error("fast mode kept after a stop");
    a_hs_fall_cause: assert property (
        $fell(hs_mode) |-> scl_i && sda_i)
        else $error("fast mode left without a stop");
    a_open_drain: assert property (
        sda_oe |-> sda_o == ISMS_SDA_LOW)
        else $error("data driven high");
    a_drive_holds: assert property (
        $rose(sda_oe) |=> sda_oe [*8])
        else $error("low drive dropped early");
    a_release_holds: assert property (
        $fell(sda_oe) |=> !sda_oe [*8])
        else $error("release cut short");
endmodule

bind isms_slave isms_slave_assertions u_chk (
    .mclk    (mclk),
    .rst     (rst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .hs_mode (hs_mode)
);
`default_nettype wire

// file: testbench/tb_i2c_serial_memory_slave.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_serial_memory_slave
    import isms_pkg::*;
;
    localparam logic [2:0] SEL   = 3'h5;
    localparam int         LIMIT = 40000;
    logic       mclk     = 1'b0;
    logic       rst      = 1'b1;
    logic       clk_en   = 1'b1;
    logic [2:0] sel_pins = SEL;
    logic       scl;
    logic       sda_m;
    logic       sda_o;
    logic       sda_oe;
    logic       hs_mode;
    wire        sda_w;
    int         failures = 0;
    int         n_tests  = 0;
    int         cyc      = 0;

    // Pull-up wins when no party pulls low
    assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
    always #2 mclk = ~mclk;

    isms_master_model u_mst (
        .mclk     (mclk),
        .sda_wire (sda_w),
        .scl      (scl),
        .sda_m    (sda_m)
    );
    isms_slave u_dut (
        .mclk               (mclk),
        .rst                (rst),
        .clk_en             (clk_en),
        .scl_i              (scl),
        .sda_i              (sda_w),
        .device_select_pins (sel_pins),
        .sda_o              (sda_o),
        .sda_oe             (sda_oe),
        .hs_mode            (hs_mode)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic set_addr(input logic [15:0] a);
        logic ack;
        u_mst.start();
        u_mst.wbyte({ISMS_DEV_TYPE, SEL, 1'b0}, ack);
        chk("write select ack", ack, 1'b1);
        u_mst.wbyte(a[15:8], ack);
        chk("addr hi ack", ack, 1'b1);
        u_mst.wbyte(a[7:0], ack);
        chk("addr lo ack", ack, 1'b1);
    endtask

    task automatic begin_read;
        logic ack;
        u_mst.start();
        u_mst.wbyte({ISMS_DEV_TYPE, SEL, 1'b1}, ack);
        chk("read select ack", ack, 1'b1);
    endtask

    task automatic wr(input logic [7:0] d);
        logic ack;
        u_mst.wbyte(d, ack);
        chk("write data ack", ack, 1'b1);
    endtask

    task automatic rd(input logic last, input logic [7:0] exp);
        logic [7:0] d;
        u_mst.rbyte(last, d);
        chk("read data", d, exp);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_write_read;
        set_addr(16'hc123);
        wr(8'ha5);
        wr(8'h3c);
        wr(8'hf0);
        u_mst.stop();
        set_addr(16'h4123);
        begin_read();
        rd(1'b0, 8'ha5);
        rd(1'b1, 8'h3c);
        u_mst.stop();
        begin_read();
        rd(1'b1, 8'hf0);
        u_mst.stop();
        $display("test write_read done");
    endtask

    task automatic t_wrap;
        set_addr(16'h7fff);
        wr(8'h5a);
        wr(8'h96);
        u_mst.stop();
        set_addr(16'hffff);
        begin_read();
        rd(1'b0, 8'h5a);
        rd(1'b1, 8'h96);
        u_mst.stop();
        $display("test wrap done");
    endtask

    task automatic t_refuse;
        logic [7:0] sa [2];
        logic       ack;
        sa[0] = {4'hb, SEL, 1'b0};
        sa[1] = {ISMS_DEV_TYPE, SEL ^ 3'h2, 1'b1};
        for (int i = 0; i < 2; i++) begin
            u_mst.start();
            u_mst.wbyte(sa[i], ack);
            chk("foreign select ack", ack, 1'b0);
            u_mst.wbyte(8'h00, ack);
            chk("ignored byte ack", ack, 1'b0);
            u_mst.stop();
        end
        $display("test refuse done");
    endtask

    task automatic t_abort;
        logic       r;
        logic [7:0] d;
        set_addr(16'h0100);
        wr(8'h77);
        wr(8'h42);
        u_mst.stop();
        // Partial byte then a start: nothing written, latch kept
        set_addr(16'h0101);
        for (int i = 0; i < 4; i++) begin
            u_mst.bit_xfer(i[0], r);
        end
        begin_read();
        rd(1'b1, 8'h42);
        u_mst.rbyte(1'b1, d);
        chk("released after nack", d, 16'h00ff);
        u_mst.stop();
        // Partial byte then a stop
        set_addr(16'h0100);
        for (int i = 0; i < 5; i++) begin
            u_mst.bit_xfer(1'b0, r);
        end
        u_mst.stop();
        begin_read();
        rd(1'b1, 8'h77);
        u_mst.stop();
        $display("test abort done");
    endtask

    task automatic t_hs;
        logic ack;
        u_mst.start();
        u_mst.wbyte(8'h0f, ack);
        chk("master code ack", ack, 1'b0);
        chk("fast mode on", hs_mode, 1'b1);
        set_addr(16'h0100);
        chk("fast mode held", hs_mode, 1'b1);
        u_mst.stop();
        chk("fast mode off", hs_mode, 1'b0);
        $display("test fast_mode done");
    endtask

    task automatic t_freeze_reset;
        logic ack;
        // Frozen device must miss a whole frame
        clk_en <= 1'b0;
        u_mst.start();
        u_mst.wbyte({ISMS_DEV_TYPE, SEL, 1'b0}, ack);
        chk("frozen select ack", ack, 1'b0);
        u_mst.stop();
        clk_en <= 1'b1;
        // Latch returns to zero while memory keeps its bytes
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (10) @(posedge mclk);
        begin_read();
        rd(1'b1, 8'h96);
        u_mst.stop();
        $display("test freeze_reset done");
    endtask

    // ==========================================================
    // Sequence and hang guard
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (10) @(posedge mclk);
        t_write_read();
        t_wrap();
        t_refuse();
        t_abort();
        t_hs();
        t_freeze_reset();
        tally_and_finish();
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures++;
            $display("Timeout after %0d cycles", cyc);
            tally_and_finish();
        end
    end
endmodule
`default_nettype wire
